// ==== irm_chan_filter.v ====
`timescale 1ns/1ps
`default_nettype none
`include "irm_consts.vh"

module irm_chan_filter
(
    input wire clk,
    input wire rst,
    input wire pkt_valid,
    input wire [`IRM_CHAN_W-1:0] pkt_channel,
    input wire [`IRM_MASK_W-1:0] mask,
    output reg pkt_accept,
    output reg pkt_drop,
    output reg pkt_lower
);

    wire is_upper;
    wire [`IRM_CHAN_W-2:0] bit_index;
    wire enabled;

    // Channel 32..63 has bit 5 set; low five bits pick the mask bit
    assign is_upper = pkt_channel[`IRM_CHAN_W-1];
    assign bit_index = pkt_channel[`IRM_CHAN_W-2:0];
    assign enabled = mask[bit_index];

    // One decision pulse per packet header; lower channels go elsewhere
    always @(posedge clk)
    begin
        if (rst)
        begin
            pkt_accept <= 1'b0;
            pkt_drop <= 1'b0;
            pkt_lower <= 1'b0;
        end
        else
        begin
            pkt_accept <= pkt_valid & is_upper & enabled;
            pkt_drop <= pkt_valid & is_upper & ~enabled;
            pkt_lower <= pkt_valid & ~is_upper;
        end
    end

endmodule // irm_chan_filter
`default_nettype wire

// ==== irm_consts.vh ====
`ifndef IRM_CONSTS_VH
`define IRM_CONSTS_VH

// Register byte offsets of the upper channel mask
`define IRM_OFS_UPPER_SET 8'h70
`define IRM_OFS_UPPER_CLEAR 8'h74

// Address width decoded by the slave
`define IRM_ADDR_W 8

// Mask geometry
`define IRM_MASK_W 32
`define IRM_CHAN_W 6
`define IRM_CHAN_BASE 6'h20

// Value loaded at reset; software must program the mask anyway
`define IRM_MASK_RESET 32'h00000000

// AXI4-Lite response codes
`define IRM_RESP_OKAY 2'h0
`define IRM_RESP_DECERR 2'h3

// Word alignment bits of an address
`define IRM_ADDR_LSB 2

// Byte lanes of the data word
`define IRM_LANE_W 8
`define IRM_LANES 4

// Clear values of held and returned words
`define IRM_WORD_ZERO 32'h00000000
`define IRM_STRB_ZERO 4'h0

`endif

// ==== irm_upper_mask.v ====
`timescale 1ns/1ps
`default_nettype none
`include "irm_consts.vh"

module irm_upper_mask
(
    input wire clk,
    input wire rst,
    // AXI4-Lite write address
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [`IRM_ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    // AXI4-Lite write data
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    // AXI4-Lite write response
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    output reg [1:0] s_axi_bresp,
    // AXI4-Lite read address
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    input wire [`IRM_ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    // AXI4-Lite read data
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    // Receive path, same clock
    input wire rx_pkt_valid,
    input wire [`IRM_CHAN_W-1:0] rx_pkt_channel,
    output wire rx_pkt_accept,
    output wire rx_pkt_drop,
    output wire rx_pkt_lower,
    // Mask seen by the receive path
    output wire [`IRM_MASK_W-1:0] rx_channel_enable,
    output wire rx_enable_top_channel,
    output wire rx_enable_first_upper_channel
);

    reg [`IRM_MASK_W-1:0] mask;
    wire [`IRM_MASK_W-1:0] next_mask;

    reg aw_full;
    reg [`IRM_ADDR_W-1:0] aw_addr;
    reg w_full;
    reg [31:0] w_data;
    reg [3:0] w_strb;

    wire aw_take;
    wire w_take;
    wire have_aw;
    wire have_w;
    wire do_write;
    wire [`IRM_ADDR_W-1:0] wr_addr;
    wire [31:0] wr_data;
    wire [3:0] wr_strb;
    wire [`IRM_ADDR_W-1:0] wr_word;
    wire wr_at_set;
    wire wr_at_clear;
    wire wr_set_hit;
    wire wr_clear_hit;
    wire wr_hit;
    wire [`IRM_MASK_W-1:0] lane_bits;
    wire [`IRM_MASK_W-1:0] ones_written;

    wire ar_take;
    wire [`IRM_ADDR_W-1:0] rd_word;
    wire rd_at_set;
    wire rd_at_clear;
    wire rd_hit;

    // Protection bits carry no meaning for this register pair
    wire unused_prot;
    assign unused_prot = ^{s_axi_awprot, s_axi_arprot};

    // Each channel holds one item until the write completes
    assign s_axi_awready = ~aw_full & ~s_axi_bvalid;
    assign s_axi_wready = ~w_full & ~s_axi_bvalid;

    // Halves taken this cycle, or held from an earlier one
    assign aw_take = s_axi_awvalid & s_axi_awready;
    assign w_take = s_axi_wvalid & s_axi_wready;
    assign have_aw = aw_full | aw_take;
    assign have_w = w_full | w_take;
    assign do_write = have_aw & have_w;

    // Use the held copy if that half arrived earlier
    assign wr_addr = aw_full ? aw_addr : s_axi_awaddr;
    assign wr_data = w_full ? w_data : s_axi_wdata;
    assign wr_strb = w_full ? w_strb : s_axi_wstrb;

    // Word decode ignores the two byte-offset bits
    assign wr_word = {wr_addr[`IRM_ADDR_W-1:`IRM_ADDR_LSB], {`IRM_ADDR_LSB{1'b0}}};
    assign wr_at_set = (wr_word == `IRM_OFS_UPPER_SET);
    assign wr_at_clear = (wr_word == `IRM_OFS_UPPER_CLEAR);
    assign wr_hit = wr_at_set | wr_at_clear;

    // A hit only counts with both address and data on hand
    assign wr_set_hit = do_write & wr_at_set;
    assign wr_clear_hit = do_write & wr_at_clear;

    // Byte strobes widened to one enable per mask bit
    genvar gl;
    generate
        for (gl = 0; gl < `IRM_LANES; gl = gl + 1)
        begin : g_lane
            assign lane_bits[gl * `IRM_LANE_W +: `IRM_LANE_W] = {`IRM_LANE_W{wr_strb[gl]}};
        end
    endgenerate

    // Only ones in an enabled lane act; zeros never touch the mask
    assign ones_written = wr_data & lane_bits;

    // Per-bit set/clear; a disabled byte lane protects its bits
    genvar gi;
    generate
        for (gi = 0; gi < `IRM_MASK_W; gi = gi + 1)
        begin : g_mask_bit
            wire set_here;
            wire clear_here;
            reg next_bit;

            // Set and clear hits never meet: one write at a time
            assign set_here = wr_set_hit & ones_written[gi];
            assign clear_here = wr_clear_hit & ones_written[gi];

            // Bit keeps its value unless a one lands on it
            always @*
            begin
                if (set_here)
                begin
                    next_bit = 1'b1;
                end
                else if (clear_here)
                begin
                    next_bit = 1'b0;
                end
                else
                begin
                    next_bit = mask[gi];
                end
            end
            assign next_mask[gi] = next_bit;
        end
    endgenerate

    // Mask storage; the reset load is only a tidy start, not a promise
    always @(posedge clk)
    begin
        if (rst)
        begin
            mask <= `IRM_MASK_RESET;
        end
        else
        begin
            mask <= next_mask;
        end
    end

    // Hold the address half if it came before the data half
    always @(posedge clk)
    begin
        if (rst)
        begin
            aw_full <= 1'b0;
            aw_addr <= {`IRM_ADDR_W{1'b0}};
        end
        else if (do_write)
        begin
            aw_full <= 1'b0;
        end
        else if (aw_take)
        begin
            aw_full <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end
    end

    // Hold the data half if it came before the address half
    always @(posedge clk)
    begin
        if (rst)
        begin
            w_full <= 1'b0;
            w_data <= `IRM_WORD_ZERO;
            w_strb <= `IRM_STRB_ZERO;
        end
        else if (do_write)
        begin
            w_full <= 1'b0;
        end
        else if (w_take)
        begin
            w_full <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
        end
    end

    // Write response stands until the master takes it
    always @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_bvalid <= 1'b0;
        end
        else if (do_write)
        begin
            s_axi_bvalid <= 1'b1;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Unmapped addresses answer a decode error and change nothing
    always @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_bresp <= `IRM_RESP_OKAY;
        end
        else if (do_write)
        begin
            s_axi_bresp <= wr_hit ? `IRM_RESP_OKAY : `IRM_RESP_DECERR;
        end
    end

    // One read at a time; address accepted only while no data waits
    assign s_axi_arready = ~s_axi_rvalid;
    assign ar_take = s_axi_arvalid & s_axi_arready;

    // Read word decode, the same two offsets as for writes
    assign rd_word = {s_axi_araddr[`IRM_ADDR_W-1:`IRM_ADDR_LSB], {`IRM_ADDR_LSB{1'b0}}};
    assign rd_at_set = (rd_word == `IRM_OFS_UPPER_SET);
    assign rd_at_clear = (rd_word == `IRM_OFS_UPPER_CLEAR);
    assign rd_hit = rd_at_set | rd_at_clear;

    // Read data stands until the master takes it
    always @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_rvalid <= 1'b0;
        end
        else if (ar_take)
        begin
            s_axi_rvalid <= 1'b1;
        end
        else if (s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Both offsets return the live mask; reading never alters it
    always @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_rdata <= `IRM_WORD_ZERO;
        end
        else if (ar_take)
        begin
            s_axi_rdata <= rd_hit ? mask : `IRM_WORD_ZERO;
        end
    end

    // Unmapped reads are refused with a decode error
    always @(posedge clk)
    begin
        if (rst)
        begin
            s_axi_rresp <= `IRM_RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_rresp <= rd_hit ? `IRM_RESP_OKAY : `IRM_RESP_DECERR;
        end
    end

    // Mask straight from its flip-flops to the receive path
    assign rx_channel_enable = mask;

    // Named taps for channel 63 and channel 32
    assign rx_enable_top_channel = mask[`IRM_MASK_W-1];
    assign rx_enable_first_upper_channel = mask[0];

    // Per-packet accept/drop decision for channels 32..63
    irm_chan_filter irm_chan_filter_inst
    (
        .clk(clk),
        .rst(rst),
        .pkt_valid(rx_pkt_valid),
        .pkt_channel(rx_pkt_channel),
        .mask(mask),
        .pkt_accept(rx_pkt_accept),
        .pkt_drop(rx_pkt_drop),
        .pkt_lower(rx_pkt_lower)
    );

endmodule // irm_upper_mask
`default_nettype wire

// ==== irm_upper_mask_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
module irm_upper_mask_checker (
    input wire clk,
    input wire rst,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_bvalid,
    input wire [1:0] s_axi_bresp,
    input wire s_axi_arvalid,
    input wire s_axi_arready,
    input wire [7:0] s_axi_araddr,
    input wire [31:0] s_axi_rdata,
    input wire [1:0] s_axi_rresp,
    input wire rx_pkt_valid,
    input wire [5:0] rx_pkt_channel,
    input wire rx_pkt_accept,
    input wire rx_pkt_drop,
    input wire rx_pkt_lower,
    input wire [31:0] rx_channel_enable,
    input wire rx_enable_top_channel,
    input wire rx_enable_first_upper_channel
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // Lane mask, decode hits and the mask bit a packet selects
    wire [31:0] bm = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wire aw_hit = s_axi_awaddr[7:3] == 5'h0e;
    wire ar_hit = s_axi_araddr[7:3] == 5'h0e;
    wire ch_bit = rx_channel_enable[rx_pkt_channel[4:0]];
    // Both write halves on one edge; only then is the lane effect checked
    sequence s_wr;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_at(ofs);
        s_wr ##0 s_axi_awaddr[7:2] == ofs;
    endsequence
    property p_set;
        s_wr_at(6'h1c) |=> rx_channel_enable == ($past(rx_channel_enable) | ($past(s_axi_wdata) & $past(bm)));
    endproperty
    property p_clr;
        s_wr_at(6'h1d) |=> rx_channel_enable == ($past(rx_channel_enable) & ~($past(s_axi_wdata) & $past(bm)));
    endproperty
    property p_bresp;
        s_wr |=> s_axi_bvalid && s_axi_bresp == ($past(aw_hit) ? 2'h0 : 2'h3);
    endproperty
    property p_rd;
        s_axi_arvalid && s_axi_arready && ar_hit |=> s_axi_rdata == $past(rx_channel_enable) && s_axi_rresp == 2'h0;
    endproperty
    property p_rd_bad;
        s_axi_arvalid && s_axi_arready && !ar_hit |=> s_axi_rresp == 2'h3;
    endproperty
    property p_keep;
        $changed(rx_channel_enable) |-> $rose(s_axi_bvalid);
    endproperty
    property p_acc;
        rx_pkt_valid && rx_pkt_channel[5] |=> rx_pkt_accept == $past(ch_bit) && rx_pkt_drop != rx_pkt_accept;
    endproperty
    property p_lower;
        rx_pkt_valid && !rx_pkt_channel[5] |=> rx_pkt_lower && !rx_pkt_accept && !rx_pkt_drop;
    endproperty
    property p_map;
        rx_enable_top_channel == rx_channel_enable[31] && rx_enable_first_upper_channel == rx_channel_enable[0];
    endproperty
    a_set: assert property (p_set) else $error("set write gave wrong mask");
    a_clr: assert property (p_clr) else $error("clear write gave wrong mask");
    a_bresp: assert property (p_bresp) else $error("write response wrong");
    a_rd: assert property (p_rd) else $error("read data differs from mask");
    a_rd_bad: assert property (p_rd_bad) else $error("unmapped read not refused");
    a_keep: assert property (p_keep) else $error("mask moved without a write");
    a_acc: assert property (p_acc) else $error("packet verdict wrong");
    a_map: assert property (p_map) else $error("channel bit mapping wrong");
    a_lower: assert property (p_lower) else $error("lower channel not passed on");
endmodule // irm_upper_mask_checker
bind irm_upper_mask irm_upper_mask_checker irm_upper_mask_checker_inst (.*);
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(e, o) begin compares++; if ((e) !== (o)) begin n_fail++; $display("mismatch t=%0t exp=%h got=%h", $time, e, o); end end
module testbench;
    logic clk = 1'h0, rst = 1'h1, s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, rx_pkt_valid = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0, a;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = 32'h0, m;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic [5:0] rx_pkt_channel = 6'h0;
    logic [35:0] q[$], exp, obs;
    wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire rx_pkt_accept, rx_pkt_drop, rx_pkt_lower, rx_enable_top_channel, rx_enable_first_upper_channel;
    wire [1:0] s_axi_bresp, s_axi_rresp;
    wire [31:0] s_axi_rdata, rx_channel_enable;
    int n_fail = 0, compares = 0;
    irm_upper_mask irm_upper_mask_inst (.*);
    initial forever #25 clk = ~clk;
    task automatic report_and_stop;
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // Write: both halves offered together, each dropped once taken; model tracks the mask
    task automatic wr(input logic [7:0] ad, input logic [31:0] d, input logic [3:0] s);
        logic ta, tw;
        logic [31:0] b;
        b = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        ta = 1'h0;
        tw = 1'h0;
        @(posedge clk);
        s_axi_awvalid <= 1'h1;
        s_axi_awaddr <= ad;
        s_axi_wvalid <= 1'h1;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_bready <= 1'h1;
        q.push_back({2'h1, ad[7:3] == 5'h0e ? 2'h0 : 2'h3, 32'h0});
        if (ad[7:3] == 5'h0e)
            m = ad[2] ? m & ~(d & b) : m | (d & b);
        while (!(ta && tw))
        begin
            @(negedge clk);
            ta = ta | (s_axi_awvalid & s_axi_awready);
            tw = tw | (s_axi_wvalid & s_axi_wready);
            @(posedge clk);
            if (ta) s_axi_awvalid <= 1'h0;
            if (tw) s_axi_wvalid <= 1'h0;
        end
        do @(negedge clk); while (!s_axi_bvalid);
        `CHK(m, rx_channel_enable)
        `CHK(({m[31], m[0]}), ({rx_enable_top_channel, rx_enable_first_upper_channel}))
        @(posedge clk);
        s_axi_bready <= 1'h0;
    endtask
    // Read: unmapped places answer zero data with a refusal code
    task automatic rd(input logic [7:0] ad);
        @(posedge clk);
        s_axi_arvalid <= 1'h1;
        s_axi_araddr <= ad;
        s_axi_rready <= 1'h1;
        q.push_back(ad[7:3] == 5'h0e ? {2'h2, 2'h0, m} : {2'h2, 2'h3, 32'h0});
        do @(negedge clk); while (!s_axi_arready);
        @(posedge clk);
        s_axi_arvalid <= 1'h0;
        do @(negedge clk); while (!s_axi_rvalid);
        @(posedge clk);
        s_axi_rready <= 1'h0;
    endtask
    // Watcher: results sampled mid-cycle, so no race with the design's edge
    always @(negedge clk)
    begin
        obs = s_axi_bvalid && s_axi_bready ? {2'h1, s_axi_bresp, 32'h0} : s_axi_rvalid && s_axi_rready ?
            {2'h2, s_axi_rresp, s_axi_rdata} : {2'h3, 31'h0, rx_pkt_accept, rx_pkt_drop, rx_pkt_lower};
        if (obs[35:34] != 2'h3 || obs[2:0] != 3'h0)
        begin
            exp = q.pop_front();
            `CHK(exp, obs)
        end
    end
    initial
    begin
        void'($urandom(68));
        repeat (10) @(posedge clk);
        rst <= 1'h0;
        wr(8'h74, 32'hffffffff, 4'hf);
        wr(8'h70, 32'h80000001, 4'hf);
        rd(8'h70);
        rd(8'h74);
        // Reset in mid-run: bus idle again, mask must be programmed anew
        @(posedge clk);
        rst <= 1'h1;
        repeat (2) @(posedge clk);
        rst <= 1'h0;
        @(negedge clk);
        `CHK(5'h07, ({s_axi_bvalid, s_axi_rvalid, s_axi_awready, s_axi_wready, s_axi_arready}))
        m = 32'hx;
        wr(8'h74, 32'hffffffff, 4'hf);
        repeat (30)
        begin
            a = 8'($urandom) & 8'hfc;
            if ($urandom % 4 != 0) a = 8'h70 | (a & 8'h04);
            wr(a, $urandom, 4'($urandom));
            rd(a ^ 8'h04);
        end
        // Every channel back to back, lower half only flagged
        for (int i = 0; i < 64; i++)
        begin
            @(posedge clk);
            rx_pkt_valid <= 1'h1;
            rx_pkt_channel <= i[5:0];
            q.push_back({2'h3, 31'h0, i[5] & m[i[4:0]], i[5] & ~m[i[4:0]], ~i[5]});
        end
        @(posedge clk);
        rx_pkt_valid <= 1'h0;
        repeat (4) @(posedge clk);
        `CHK(0, q.size())
        report_and_stop;
    end
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        report_and_stop;
    end
endmodule // testbench
`default_nettype wire
